// file: ocd_cfg.svh
// Option decoder constants: field positions, widths, encodings and reset values
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH

// -----------------------------------------------------------------------------
// Option word layout
// -----------------------------------------------------------------------------
`define OCD_OPT_W          18
`define OCD_HSEL_LSB       0
`define OCD_LSEL_BIT       2
`define OCD_WSRC_BIT       3
`define OCD_IRCF_LSB       4
`define OCD_RPIN_BIT       6
`define OCD_WDTE_BIT       7
`define OCD_WCLR_BIT       8
`define OCD_BOE_BIT        9
`define OCD_BOV_LSB        10
`define OCD_SIME_BIT       12
`define OCD_WRITE_COLLISION_FLAG_BIT       13
`define OCD_CHIP_SELECT_ENABLE_BIT_BIT       14
`define OCD_DBN_LSB        15
`define OCD_OPT_VALID_BIT  17

// -----------------------------------------------------------------------------
// Encodings
// -----------------------------------------------------------------------------
`define OCD_HS_XTAL        2'h0
`define OCD_HS_ERC         2'h1
`define OCD_HS_IRC         2'h2
`define OCD_IRC_4M         2'h0
`define OCD_IRC_8M         2'h1
`define OCD_IRC_12M        2'h2
`define OCD_DBN_NONE       2'h0
`define OCD_DBN_2          2'h1
`define OCD_DBN_4          2'h2
`define OCD_DBN_CYC_2      3'h2
`define OCD_DBN_CYC_4      3'h4

// -----------------------------------------------------------------------------
// Safe values before the options are loaded
// -----------------------------------------------------------------------------
`define OCD_RST_OPT        18'h000C0

`endif

// file: ocd_opt_store.sv
// Option word store: captures once, then holds the word until the next reset
`include "ocd_cfg.svh"
`default_nettype none
module ocd_opt_store (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  ce_i,
    input  wire logic                  load_i,
    input  wire logic [`OCD_OPT_W-1:0] opt_i,
    output logic      [`OCD_OPT_W-1:0] opt_o,
    output logic                       loaded_o
);
    logic [`OCD_OPT_W-1:0] next_opt;
    logic                  next_loaded;

    // single capture: once loaded only reset reopens the store
    always_comb begin
        next_opt    = opt_o;
        next_loaded = loaded_o;
        if (ce_i && load_i && !loaded_o) begin
            next_opt    = opt_i;
            next_loaded = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_o    <= `OCD_RST_OPT;
            loaded_o <= 1'b0;
        end else begin
            opt_o    <= next_opt;
            loaded_o <= next_loaded;
        end
    end

    AST_STORE_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(loaded_o) |-> $stable(opt_o))
        else $error("option store changed after load");
endmodule
`default_nettype wire

// file: ocd_option_decoder.sv
// Option decoder: turns the programmed option word into fixed control outputs
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`include "ocd_cfg.svh"
`default_nettype none
module ocd_option_decoder (
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ce_i,
    input  wire logic [`OCD_OPT_W-1:0] opt_word_i,
    output logic      [1:0]            high_speed_clock_sel_o,
    output logic                       hs_external_crystal_osc_o,
    output logic                       hs_external_rc_osc_o,
    output logic                       hs_internal_fast_rc_osc_o,
    output logic                       low_speed_clock_irc_o,
    output logic                       sub_clock_irc_o,
    output logic                       timebase_clock_irc_o,
    output logic                       watchdog_clock_sys4_o,
    output logic      [1:0]            internal_fast_rc_freq_o,
    output logic                       port_b_bit0_clear_pin_o,
    output logic                       watchdog_en_o,
    output logic                       watchdog_clear_instr_two_o,
    output logic                       brownout_reset_en_o,
    output logic      [1:0]            brownout_reset_level_o,
    output logic                       serial_interface_unit_en_o,
    output logic                       write_collision_flag_en_o,
    output logic                       chip_select_enable_bit_en_o,
    output logic      [2:0]            i2c_debounce_cycles_o,
    output logic                       opt_error_o,
    output logic                       units_release_o
);
    // -------------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else if (ce_i) begin
            // Release also waits on the enable, so a stalled clock delays every step
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // -------------------------------------------------------------------------
    // Load sequence
    // -------------------------------------------------------------------------
    ocd_pkg::ocd_state_e state;
    ocd_pkg::ocd_state_e next_state;
    logic [`OCD_OPT_W-1:0] opt;
    logic                  loaded;
    logic                  load;

    // capture straight after reset release, before units run
    always_comb begin
        next_state = state;
        load       = 1'b0;
        case (state)
            ocd_pkg::OCD_ST_LOAD: begin
                load       = 1'b1;
                next_state = ocd_pkg::OCD_ST_HOLD;
            end
            ocd_pkg::OCD_ST_HOLD: begin
                if (loaded) begin
                    next_state = ocd_pkg::OCD_ST_RUN;
                end
            end
            ocd_pkg::OCD_ST_RUN: begin
                next_state = ocd_pkg::OCD_ST_RUN;
            end
            default: begin
                next_state = ocd_pkg::OCD_ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ocd_pkg::OCD_ST_LOAD;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    ocd_opt_store u_store (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .ce_i     (ce_i),
        .load_i   (load),
        .opt_i    (opt_word_i),
        .opt_o    (opt),
        .loaded_o (loaded)
    );

    // -------------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------------
    logic [1:0] hs;
    logic [1:0] irc;
    logic [1:0] dbn;
    logic [2:0] next_dbn_cyc;
    logic       next_err;
    logic       valid;

    assign hs  = opt[`OCD_HSEL_LSB +: 2];
    assign irc = opt[`OCD_IRCF_LSB +: 2];
    assign dbn = opt[`OCD_DBN_LSB +: 2];
    assign valid = (state == ocd_pkg::OCD_ST_RUN);

    always_comb begin
        case (dbn)
            `OCD_DBN_NONE: next_dbn_cyc = 3'h0;
            `OCD_DBN_2:    next_dbn_cyc = `OCD_DBN_CYC_2;
            `OCD_DBN_4:    next_dbn_cyc = `OCD_DBN_CYC_4;
            default:       next_dbn_cyc = 3'h0;
        endcase
    end

    // flag undefined codes and a clear valid bit; an undefined code falls back to safe defaults
    assign next_err = (hs == 2'h3) || (irc == 2'h3) || (dbn == 2'h3)
                      || !opt[`OCD_OPT_VALID_BIT];

    // -------------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------------
    // Outputs update from the store on every enabled cycle, its reset value included before load, so they track it one cycle late
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            high_speed_clock_sel_o      <= `OCD_HS_IRC;
            hs_external_crystal_osc_o   <= 1'b0;
            hs_external_rc_osc_o        <= 1'b0;
            hs_internal_fast_rc_osc_o   <= 1'b1;
            low_speed_clock_irc_o       <= 1'b1;
            sub_clock_irc_o             <= 1'b1;
            timebase_clock_irc_o        <= 1'b1;
            watchdog_clock_sys4_o       <= 1'b0;
            internal_fast_rc_freq_o     <= `OCD_IRC_4M;
            port_b_bit0_clear_pin_o     <= 1'b1;
            watchdog_en_o               <= 1'b1;
            watchdog_clear_instr_two_o  <= 1'b0;
            brownout_reset_en_o         <= 1'b0;
            brownout_reset_level_o      <= 2'h0;
            serial_interface_unit_en_o  <= 1'b0;
            write_collision_flag_en_o   <= 1'b0;
            chip_select_enable_bit_en_o <= 1'b0;
            i2c_debounce_cycles_o       <= 3'h0;
            opt_error_o                 <= 1'b0;
            units_release_o             <= 1'b0;
        end else if (ce_i) begin
            // one-hot high-speed source, undefined code falls to internal RC
            high_speed_clock_sel_o      <= (hs == 2'h3) ? `OCD_HS_IRC : hs;
            hs_external_crystal_osc_o   <= (hs == `OCD_HS_XTAL);
            hs_external_rc_osc_o        <= (hs == `OCD_HS_ERC);
            hs_internal_fast_rc_osc_o   <= (hs == `OCD_HS_IRC) || (hs == 2'h3);
            low_speed_clock_irc_o       <= opt[`OCD_LSEL_BIT];
            // sub and time-base follow low-speed choice
            sub_clock_irc_o             <= opt[`OCD_LSEL_BIT];
            timebase_clock_irc_o        <= opt[`OCD_LSEL_BIT];
            watchdog_clock_sys4_o       <= opt[`OCD_WSRC_BIT];
            internal_fast_rc_freq_o     <= (irc == 2'h3) ? `OCD_IRC_4M : irc;
            port_b_bit0_clear_pin_o     <= opt[`OCD_RPIN_BIT];
            watchdog_en_o               <= opt[`OCD_WDTE_BIT];
            watchdog_clear_instr_two_o  <= opt[`OCD_WCLR_BIT];
            brownout_reset_en_o         <= opt[`OCD_BOE_BIT];
            brownout_reset_level_o      <= opt[`OCD_BOV_LSB +: 2];
            serial_interface_unit_en_o  <= opt[`OCD_SIME_BIT];
            write_collision_flag_en_o   <= opt[`OCD_SIME_BIT] & opt[`OCD_WRITE_COLLISION_FLAG_BIT];
            chip_select_enable_bit_en_o <= opt[`OCD_SIME_BIT] & opt[`OCD_CHIP_SELECT_ENABLE_BIT_BIT];
            i2c_debounce_cycles_o       <= next_dbn_cyc;
            opt_error_o                 <= valid & next_err;
            // release units only after decode is stable
            units_release_o             <= valid;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    AST_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n)
        $past(units_release_o) |-> $stable(watchdog_en_o) && $stable(brownout_reset_level_o)
        && $stable(i2c_debounce_cycles_o))
        else $error("decoded option moved after release");
    AST_HS_ONEHOT: assert property (@(posedge clk_i) disable iff (!rst_n)
        $onehot({hs_external_crystal_osc_o, hs_external_rc_osc_o, hs_internal_fast_rc_osc_o}))
        else $error("high-speed source not one-hot");
    AST_SUB_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n)
        sub_clock_irc_o == low_speed_clock_irc_o && timebase_clock_irc_o == low_speed_clock_irc_o)
        else $error("sub or time-base clock disagrees with low-speed choice");
    AST_DBN_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
        units_release_o |-> i2c_debounce_cycles_o inside {3'h0, 3'h2, 3'h4})
        else $error("debounce length outside 0, 2 or 4");
    AST_WRITE_COLLISION_FLAG_GATE: assert property (@(posedge clk_i) disable iff (!rst_n)
        write_collision_flag_en_o |-> serial_interface_unit_en_o)
        else $error("collision flag live with serial unit off");
    AST_CHIP_SELECT_ENABLE_BIT_GATE: assert property (@(posedge clk_i) disable iff (!rst_n)
        chip_select_enable_bit_en_o |-> serial_interface_unit_en_o)
        else $error("chip-select bit live with serial unit off");
    AST_RELEASE_TIME: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(rst_n) && ce_i ##1 ce_i ##1 ce_i |=> units_release_o)
        else $error("units not released three enabled cycles after reset");
    AST_WDT_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n)
        units_release_o |-> watchdog_en_o == opt[`OCD_WDTE_BIT]
        && watchdog_clear_instr_two_o == opt[`OCD_WCLR_BIT])
        else $error("watchdog outputs disagree with stored option");

    COV_RELEASE: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(units_release_o));
    COV_XTAL: cover property (@(posedge clk_i) disable iff (!rst_n)
        units_release_o && hs_external_crystal_osc_o);
    COV_DBN4: cover property (@(posedge clk_i) disable iff (!rst_n) i2c_debounce_cycles_o == 3'h4);
    COV_ERR: cover property (@(posedge clk_i) disable iff (!rst_n) opt_error_o);
endmodule
`default_nettype wire

// file: ocd_pkg.sv
// Types for the option decoder
`default_nettype none
package ocd_pkg;
    typedef enum logic [1:0] {
        OCD_HS_XTAL_E = 2'h0,
        OCD_HS_ERC_E  = 2'h1,
        OCD_HS_IRC_E  = 2'h2
    } ocd_hs_e;

    typedef enum logic [2:0] {
        OCD_ST_LOAD = 3'h1,
        OCD_ST_HOLD = 3'h2,
        OCD_ST_RUN  = 3'h4
    } ocd_state_e;
endpackage
`default_nettype wire

// file: ocd_prog_model.sv
// Programming tool model: holds the option word written into the part's option storage
`include "ocd_cfg.svh"
`default_nettype none
module ocd_prog_model (
    input  wire logic                  clk_i,
    input  wire logic                  prog_i,
    input  wire logic [`OCD_OPT_W-2:0] fields_i,
    input  wire logic                  valid_i,
    output logic      [`OCD_OPT_W-1:0] opt_word_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // -------------------------------------------------------------------------
    // Option storage
    // -------------------------------------------------------------------------
    // every field defined: a blank part still reads as a full word
    initial opt_word_o = 18'h00000;

    always @(posedge clk_i) begin
        if (prog_i) begin
            opt_word_o <= {valid_i, fields_i};
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
// Testbench for the option decoder: programs words, resets, checks decoded outputs
`include "ocd_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk_i  = 1'b0;
    logic                  nrst_i = 1'b1;
    logic                  ce_i   = 1'b1;
    logic                  prog   = 1'b0;
    logic                  valid  = 1'b1;
    logic [`OCD_OPT_W-2:0] fields = 17'h00000;
    logic [`OCD_OPT_W-1:0] opt_word;
    logic [1:0] hs_sel, irc_f, bo_lvl;
    logic [2:0] dbn_cyc;
    logic       ls_irc, sub_irc, tb_irc, wd_s4, pin_rst, wd_en, wd_two, bo_en, siu_en, write_collision_flag_en, chip_select_enable_bit_en, err, rel;
    logic       hs_x, hs_e, hs_i;
    int         failures  = 0;
    int         cmp_count = 0;
    logic [`OCD_OPT_W-1:0] w;
    int         n;

    always #25 clk_i = ~clk_i;

    ocd_prog_model prog_model (
        .clk_i(clk_i), .prog_i(prog), .fields_i(fields), .valid_i(valid), .opt_word_o(opt_word)
    );

    ocd_option_decoder dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .opt_word_i(opt_word),
        .high_speed_clock_sel_o(hs_sel), .hs_external_crystal_osc_o(hs_x), .hs_external_rc_osc_o(hs_e),
        .hs_internal_fast_rc_osc_o(hs_i), .low_speed_clock_irc_o(ls_irc), .sub_clock_irc_o(sub_irc),
        .timebase_clock_irc_o(tb_irc), .watchdog_clock_sys4_o(wd_s4), .internal_fast_rc_freq_o(irc_f),
        .port_b_bit0_clear_pin_o(pin_rst), .watchdog_en_o(wd_en), .watchdog_clear_instr_two_o(wd_two),
        .brownout_reset_en_o(bo_en), .brownout_reset_level_o(bo_lvl), .serial_interface_unit_en_o(siu_en),
        .write_collision_flag_en_o(write_collision_flag_en), .chip_select_enable_bit_en_o(chip_select_enable_bit_en),
        .i2c_debounce_cycles_o(dbn_cyc), .opt_error_o(err), .units_release_o(rel)
    );

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Writes a word through the programming tool; takes effect one edge later
    task automatic program_word(input logic [`OCD_OPT_W-1:0] word);
        @(posedge clk_i);
        prog   <= 1'b1;
        fields <= word[`OCD_OPT_W-2:0];
        valid  <= word[`OCD_OPT_W-1];
        @(posedge clk_i);
        prog <= 1'b0;
    endtask

    task automatic check_decode(input logic [`OCD_OPT_W-1:0] v);
        logic [1:0] hs;
        logic       bad;
        hs  = (v[1:0] == 2'h3) ? 2'h2 : v[1:0];
        bad = (v[1:0] == 2'h3) || (v[5:4] == 2'h3) || (v[16:15] == 2'h3) || !v[17];
        cmp(hs_sel, hs, "high speed select");
        cmp({hs_i, hs_e, hs_x}, 3'h1 << hs, "high speed one-hot");
        cmp(ls_irc, v[2], "low speed source");
        cmp({sub_irc, tb_irc}, {2{v[2]}}, "sub and timebase source");
        cmp(wd_s4, v[3], "watchdog clock");
        cmp(irc_f, (v[5:4] == 2'h3) ? 2'h0 : v[5:4], "fast RC frequency");
        cmp(pin_rst, v[6], "pin function");
        cmp(wd_en, v[7], "watchdog enable");
        cmp(wd_two, v[8], "clear count");
        cmp(bo_en, v[9], "brownout enable");
        cmp(bo_lvl, v[11:10], "brownout level");
        cmp(siu_en, v[12], "serial unit enable");
        cmp(write_collision_flag_en, v[12] & v[13], "collision flag enable");
        cmp(chip_select_enable_bit_en, v[12] & v[14], "chip select enable");
        cmp(dbn_cyc, (v[16:15] == 2'h1) ? `OCD_DBN_CYC_2 : (v[16:15] == 2'h2) ? `OCD_DBN_CYC_4 : 3'h0,
            "debounce cycles");
        cmp(err, bad, "option error");
    endtask

    // Reset with the word already programmed, release, and count edges to release, stalled ones included
    task automatic run_case(input logic [`OCD_OPT_W-1:0] v, input int hold, input int stall);
        program_word(v);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (hold) @(posedge clk_i);
        #1;
        cmp({hs_sel, hs_i, ls_irc, pin_rst, wd_en, wd_s4, rel}, 8'hBC, "safe values in reset");
        @(posedge clk_i);
        nrst_i <= 1'b1;
        ce_i   <= (stall == 0);
        n = 0;
        while (n < 20) begin
            @(posedge clk_i);
            n++;
            if (n == stall) ce_i <= 1'b1;
            #1;
            if (rel === 1'b1) break;
        end
        cmp(n[7:0], 8'(stall + 5), "edges to release");
        check_decode(v);
        // Reprogramming after capture must not reach the outputs
        program_word(~v);
        repeat (3) @(posedge clk_i);
        #1;
        check_decode(v);
        cmp(rel, 1'b1, "release held");
    endtask

    // -------------------------------------------------------------------------
    // Main sequence: every code of every field, illegal codes, invalid word
    // -------------------------------------------------------------------------
    initial begin
        // A real falling edge at time zero, so the async reset acts before the first clock
        nrst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            logic [1:0] k;
            k = i[1:0];
            w = {(i != 4), k, (k == 2'h1) || (k == 2'h3), (k == 2'h1) || (k == 2'h2), (k != 2'h1), k,
                 k[1], k[0], ~k[1], k[1], k, ~k[0], k[0], k};
            run_case(w, (i == 0) ? 16 : 2, (i == 2) ? 4 : 0);
        end
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
